// ==== pkg/brc_pkg.sv ====
package brc_pkg;
    // Pin and word widths, and prefetch FIFO depth
    localparam int DATA_W = 16;
    localparam int ADDR_W = 24;
    localparam int FIFO_DEPTH = 8;
    // Identifier space offset that returns the read-setup register
    localparam logic [7:0] IDENT_OFFSET = 8'h05;
    // Reset value and writable bits of the read-setup register
    localparam logic [15:0] SETUP_RESET = 16'hF94F;
    localparam logic [15:0] SETUP_WMASK = 16'hFD4F;
    // Field positions
    localparam int BIT_READ_TYPE = 15;
    localparam int LAT_HI = 14;
    localparam int LAT_LO = 11;
    localparam int BIT_WAIT_POL = 10;
    localparam int BIT_WAIT_EARLY = 8;
    localparam int BIT_EDGE = 6;
    localparam int BIT_WRAP_DIS = 3;
    localparam int BSZ_HI = 2;
    localparam int BSZ_LO = 0;
    // Burst size codes and word counts
    localparam logic [2:0] BSZ_4 = 3'h1;
    localparam logic [2:0] BSZ_8 = 3'h2;
    localparam logic [2:0] BSZ_16 = 3'h3;
    localparam logic [4:0] LEN_4 = 5'h04;
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] LEN_CONT = 5'h00;
    // Row-end stall support
    localparam logic [3:0] LAT_STALL_MIN = 4'h5;
    localparam logic [3:0] ROW_LAST = 4'hF;
    localparam logic [3:0] ROW_FIRST = 4'h0;
    // Command byte codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
    localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;

    typedef struct packed {
        logic read_async;
        logic [3:0] latency;
        logic wait_high;
        logic wait_early;
        logic rise_edge;
        logic wrap_disable;
        logic [2:0] burst_size_field;
    } brc_cfg_s;

    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic adv_n;
        logic bclk;
        logic rst_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } brc_pins_s;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LAT   = 5'b00010,
        ST_DATA  = 5'b00100,
        ST_STALL = 5'b01000,
        ST_DONE  = 5'b10000
    } brc_state_e;

    function automatic brc_cfg_s brc_decode(input logic [15:0] r);
        brc_cfg_s c;
        c.read_async = r[BIT_READ_TYPE];
        c.latency = r[LAT_HI:LAT_LO];
        c.wait_high = r[BIT_WAIT_POL];
        c.wait_early = r[BIT_WAIT_EARLY];
        c.rise_edge = r[BIT_EDGE];
        c.wrap_disable = r[BIT_WRAP_DIS];
        c.burst_size_field = r[BSZ_HI:BSZ_LO];
        return c;
    endfunction

    // Reserved size codes run as a continuous burst
    function automatic logic [4:0] brc_len(input logic [2:0] bsz);
        logic [4:0] n;
        case (bsz)
            BSZ_4: n = LEN_4;
            BSZ_8: n = LEN_8;
            BSZ_16: n = LEN_16;
            default: n = LEN_CONT;
        endcase
        return n;
    endfunction
endpackage

// ==== hdl/brc_burst_read_config_wait.sv ====
`timescale 1ns/1ps

// Small synchronous FIFO; depth must be a power of two so pointers wrap naturally
module brc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    logic push, pop;

    // Pointer and occupancy update; flush wins over any push or pop
    always_comb begin
        push = in_valid_in && ready_q;
        pop = out_ready_in && (cnt_q != '0);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data_in;
            wr_d = wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = rd_q + 1'b1;
        end
        cnt_d = cnt_q + CW'(push) - CW'(pop);
        if (flush_in) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
        ready_d = (cnt_d != FULL_CNT);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    // Storage needs no reset; occupancy guards every read
    always_ff @(posedge clk_in) begin
        mem_q <= mem_d;
    end

    assign in_ready_out = ready_q;
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out = mem_q[rd_q];
endmodule // brc_fifo

module brc_burst_read_config_wait
    import brc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic chip_select_n_in,
    input wire logic output_enable_n_in,
    input wire logic write_enable_n_in,
    input wire logic address_valid_n_in,
    input wire logic burst_clk_in,
    input wire logic reset_n_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_n_out,
    output logic wait_out,
    output logic wait_oe_n_out,
    output logic [ADDR_W-1:0] array_addr_out,
    output logic array_req_out,
    input wire logic array_valid_in,
    input wire logic [DATA_W-1:0] array_data_in,
    output logic array_ready_out,
    output logic [15:0] read_setup_register_out
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    brc_pins_s pins_raw, pins_s1_q, pin;
    logic bclk_prev_q, we_prev_q;
    logic act_edge, we_rise, bus_active, start;
    logic [15:0] setup_q, setup_d;
    logic cfg_pend_q, cfg_pend_d, ident_q, ident_d;
    brc_cfg_s cfg;
    logic [4:0] burst_len;
    logic wrap_on;
    logic [ADDR_W-1:0] wrap_mask;
    logic [15:0] ident_word;
    brc_state_e state_q, state_d;
    logic [3:0] lat_cnt_q, lat_cnt_d, stall_cnt_q, stall_cnt_d, out_lo_q, out_lo_d;
    logic [4:0] beats_q, beats_d, ast_edges_q, ast_edges_d;
    logic stalled_q, stalled_d, unaligned_q, unaligned_d, adv_seen_q, adv_seen_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic wait_q, wait_d, wait_oe_n_q, data_oe_n_q;
    logic try_present, present_now, next_present, wait_assert;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic fetching_q, fetching_d, fifo_flush, fifo_push, fifo_pop;
    logic fifo_ready, fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    // Reset release through two stages so every flop leaves reset on one edge
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Every pin is foreign to this clock; address and data pass through the same two stages every cycle
    assign pins_raw = '{cs_n: chip_select_n_in, oe_n: output_enable_n_in,
                        we_n: write_enable_n_in, adv_n: address_valid_n_in,
                        bclk: burst_clk_in, rst_n: reset_n_in,
                        addr: address_in, data: data_pins_in};
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1, bclk: 1'b0,
                           rst_n: 1'b0, addr: '0, data: '0};
            pin <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1, bclk: 1'b0,
                     rst_n: 1'b0, addr: '0, data: '0};
            bclk_prev_q <= 1'b0;
            we_prev_q <= 1'b1;
        end else begin
            pins_s1_q <= pins_raw;
            pin <= pins_s1_q;
            bclk_prev_q <= pin.bclk;
            we_prev_q <= pin.we_n;
        end
    end

    // Strobe decode on the synchronised copies
    assign cfg = brc_decode(setup_q);
    assign act_edge = cfg.rise_edge ? (pin.bclk && !bclk_prev_q)
                                    : (!pin.bclk && bclk_prev_q);
    assign we_rise = pin.we_n && !we_prev_q && !pin.cs_n;
    assign bus_active = !pin.cs_n && !pin.oe_n && pin.rst_n;
    assign start = act_edge && bus_active && !pin.adv_n && !adv_seen_q && !cfg.read_async;
    assign burst_len = brc_len(cfg.burst_size_field);
    assign wrap_on = !cfg.wrap_disable && (burst_len != LEN_CONT);
    assign wrap_mask = ADDR_W'(burst_len) - ADDR_W'(1);
    // Only the setup word answers in identifier space; other offsets read zero
    assign ident_word = (pin.addr[7:0] == IDENT_OFFSET) ? setup_q : '0;

    // Command decoder: configure is a two-write sequence, value on the address pins
    always_comb begin
        setup_d = setup_q;
        cfg_pend_d = cfg_pend_q;
        ident_d = ident_q;
        if (!pin.rst_n) begin
            setup_d = SETUP_RESET;
            cfg_pend_d = 1'b0;
            ident_d = 1'b0;
        end else if (we_rise) begin
            if (cfg_pend_q) begin
                cfg_pend_d = 1'b0;
                if (pin.data[7:0] == CMD_CFG_CONFIRM) begin
                    setup_d = pin.addr[15:0] & SETUP_WMASK;
                end
            end else if (pin.data[7:0] == CMD_CFG_SETUP) begin
                cfg_pend_d = 1'b1;
            end else if (pin.data[7:0] == CMD_IDENT) begin
                ident_d = 1'b1;
            end else if (pin.data[7:0] == CMD_READ_ARRAY) begin
                ident_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            setup_q <= SETUP_RESET;
            cfg_pend_q <= 1'b0;
            ident_q <= 1'b0;
        end else begin
            setup_q <= setup_d;
            cfg_pend_q <= cfg_pend_d;
            ident_q <= ident_d;
        end
    end

    // Burst engine and pin drivers; burst state advances only on the selected edge, and deselect returns it to idle at once
    always_comb begin
        state_d = state_q;
        lat_cnt_d = lat_cnt_q;
        stall_cnt_d = stall_cnt_q;
        beats_d = beats_q;
        out_lo_d = out_lo_q;
        stalled_d = stalled_q;
        unaligned_d = unaligned_q;
        adv_seen_d = adv_seen_q && !pin.adv_n;
        ast_edges_d = act_edge ? (ast_edges_q + 5'h01) : ast_edges_q;
        data_d = data_q;
        wait_d = wait_q;
        try_present = 1'b0;
        present_now = 1'b0;
        next_present = 1'b0;
        wait_assert = 1'b0;
        fifo_pop = 1'b0;
        if (!bus_active) begin
            state_d = ST_IDLE;
        end else if (cfg.read_async) begin
            state_d = ST_IDLE;
            wait_d = !cfg.wait_high;
            if (ident_q) begin
                data_d = ident_word;
            end else if (array_valid_in) begin
                data_d = array_data_in;
            end
        end else begin
            if (start) begin
                state_d = ST_LAT;
                lat_cnt_d = 4'h1;
                beats_d = '0;
                out_lo_d = pin.addr[3:0];
                unaligned_d = (pin.addr[3:0] != ROW_FIRST);
                stalled_d = 1'b0;
                adv_seen_d = 1'b1;
                ast_edges_d = '0;
            end else if (act_edge) begin
                case (state_q)
                    ST_LAT: begin
                        if (lat_cnt_q >= cfg.latency) begin
                            try_present = 1'b1;
                        end else begin
                            lat_cnt_d = lat_cnt_q + 4'h1;
                        end
                    end
                    ST_DATA: try_present = 1'b1;
                    ST_STALL: begin
                        if (stall_cnt_q != '0) begin
                            stall_cnt_d = stall_cnt_q - 4'h1;
                        end else begin
                            try_present = 1'b1;
                        end
                    end
                    ST_IDLE, ST_DONE: ;
                    default: state_d = ST_IDLE;
                endcase
            end
            if (try_present) begin
                if (ident_q) begin
                    data_d = ident_word;
                    present_now = 1'b1;
                end else if (fifo_out_valid) begin
                    data_d = fifo_out_data;
                    fifo_pop = 1'b1;
                    present_now = 1'b1;
                end else begin
                    // Array fell behind: in late wait mode, hold wait asserted until a word arrives
                    state_d = ST_STALL;
                    stall_cnt_d = '0;
                end
            end
            if (present_now) begin
                beats_d = beats_q + 5'h01;
                out_lo_d = out_lo_q + 4'h1;
                state_d = ST_DATA;
                if (burst_len != LEN_CONT && beats_d == burst_len) begin
                    state_d = ST_DONE;
                end else if (out_lo_q == ROW_LAST && unaligned_q && !stalled_q && !wrap_on
                             && !ident_q && cfg.latency >= LAT_STALL_MIN) begin
                    state_d = ST_STALL;
                    stall_cnt_d = cfg.latency - 4'h1;
                    stalled_d = 1'b1;
                end
            end
            // Early mode looks one edge ahead; it cannot foresee an array underrun
            next_present = (state_d == ST_LAT && lat_cnt_d >= cfg.latency)
                           || state_d == ST_DATA || state_d == ST_DONE
                           || (state_d == ST_STALL && stall_cnt_d == '0);
            wait_assert = (state_d != ST_DONE)
                          && (cfg.wait_early ? !next_present : !present_now);
            if (start || (act_edge && state_q != ST_IDLE)) begin
                wait_d = cfg.wait_high ? wait_assert : !wait_assert;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            lat_cnt_q <= '0;
            stall_cnt_q <= '0;
            beats_q <= '0;
            out_lo_q <= '0;
            stalled_q <= 1'b0;
            unaligned_q <= 1'b0;
            adv_seen_q <= 1'b0;
            ast_edges_q <= '0;
            data_q <= '0;
            wait_q <= 1'b1;
            wait_oe_n_q <= 1'b1;
            data_oe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            lat_cnt_q <= lat_cnt_d;
            stall_cnt_q <= stall_cnt_d;
            beats_q <= beats_d;
            out_lo_q <= out_lo_d;
            stalled_q <= stalled_d;
            unaligned_q <= unaligned_d;
            adv_seen_q <= adv_seen_d;
            ast_edges_q <= ast_edges_d;
            data_q <= data_d;
            wait_q <= wait_d;
            wait_oe_n_q <= !bus_active;
            data_oe_n_q <= !bus_active;
        end
    end

    // Array prefetch: words are fetched ahead into the FIFO from the burst start
    always_comb begin
        fetching_d = fetching_q;
        addr_d = addr_q;
        fifo_flush = start || !bus_active;
        fifo_push = array_valid_in && fetching_q;
        if (!bus_active) begin
            fetching_d = 1'b0;
        end
        if (cfg.read_async) begin
            addr_d = pin.addr;
            fetching_d = 1'b0;
        end else if (start) begin
            addr_d = pin.addr;
            fetching_d = !ident_q;
        end else if (fifo_push && fifo_ready) begin
            if (wrap_on) begin
                addr_d = (addr_q & ~wrap_mask) | ((addr_q + ADDR_W'(1)) & wrap_mask);
            end else begin
                addr_d = addr_q + ADDR_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fetching_q <= 1'b0;
            addr_q <= '0;
        end else begin
            fetching_q <= fetching_d;
            addr_q <= addr_d;
        end
    end

    brc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .flush_in(fifo_flush),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_ready),
        .in_data_in(array_data_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out_data)
    );

    assign data_pins_out = data_q;
    assign data_pins_oe_n_out = data_oe_n_q;
    assign wait_out = wait_q;
    assign wait_oe_n_out = wait_oe_n_q;
    assign array_addr_out = addr_q;
    assign array_req_out = fetching_q;
    assign array_ready_out = fifo_ready;
    assign read_setup_register_out = setup_q;

    AST_RESET_DEFAULT: assert property (
        !pin.rst_n |=> setup_q == SETUP_RESET)
        else $error("read setup not defaulted by reset pin");
    AST_RSVD_ZERO: assert property (
        (setup_q & ~SETUP_WMASK) == 16'h0000)
        else $error("reserved setup bits not zero");
    AST_CFG_WRITE: assert property (
        pin.rst_n && we_rise && cfg_pend_q && pin.data[7:0] == CMD_CFG_CONFIRM
        |=> setup_q == ($past(pin.addr[15:0]) & SETUP_WMASK))
        else $error("configure write not stored");
    AST_FLOAT: assert property (
        !bus_active |=> wait_oe_n_out && data_pins_oe_n_out)
        else $error("pins driven outside active read");
    AST_ASYNC_DEASSERT: assert property (
        cfg.read_async && bus_active |=> wait_out == !$past(cfg.wait_high))
        else $error("wait not deasserted in asynchronous read");
    AST_WAIT_STABLE: assert property (
        !cfg.read_async && !act_edge |=> $stable(wait_out))
        else $error("wait moved without a valid edge");
    AST_LATENCY: assert property (
        present_now && beats_q == 5'h00 && ident_q && cfg.latency >= 4'h1
        |-> (ast_edges_q + 5'h01) == {1'b0, cfg.latency})
        else $error("first word not at programmed latency");
    AST_REPEAT: assert property (
        present_now && ident_q |=> data_pins_out == $past(ident_word))
        else $error("nonarray word not repeated");
    AST_WAIT_LATE: assert property (
        present_now && !cfg.wait_early |=> wait_out == !$past(cfg.wait_high))
        else $error("wait asserted with valid data");
    AST_BURST_END: assert property (
        present_now && burst_len != LEN_CONT && beats_d == burst_len
        |=> state_q == ST_DONE ##1 wait_out == !cfg.wait_high || bus_active == 1'b0
            || act_edge == 1'b0)
        else $error("burst did not end at programmed length");
    AST_STALL_RANGE: assert property (
        state_q == ST_STALL && stall_cnt_q != 4'h0
        |-> cfg.latency >= LAT_STALL_MIN && stall_cnt_q < cfg.latency)
        else $error("row-end stall out of range");
    AST_WRAP: assert property (
        fifo_push && fifo_ready && wrap_on && !start && !cfg.read_async
        |=> (addr_q & ~$past(wrap_mask)) == ($past(addr_q) & ~$past(wrap_mask)))
        else $error("wrapped burst left its boundary");
endmodule // brc_burst_read_config_wait

// ==== testbench/brc_host_model.sv ====
`timescale 1ns/1ps
// Host controller: every pin change is held for several system cycles,
// because the device samples its pins through a two-stage synchroniser
module brc_host_model
    import brc_pkg::*;
(
    input wire logic clk_in,
    output logic cs_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic adv_n_out,
    output logic bclk_out,
    output logic rst_n_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] data_out
);
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Command write: code on the low data byte, value on the address
    task automatic cmd(input logic [7:0] code, input logic [ADDR_W-1:0] a);
        cs_n_out <= 1'b0;
        we_n_out <= 1'b0;
        addr_out <= a;
        data_out <= {8'h00, code};
        hold(4);
        we_n_out <= 1'b1;
        hold(4);
        cs_n_out <= 1'b1;
        data_out <= ~data_out; // Released bus must not keep the last value
        hold(4);
    endtask
    // Start a read cycle with address valid held low
    task automatic sel(input logic on, input logic [ADDR_W-1:0] a);
        cs_n_out <= !on;
        oe_n_out <= !on;
        adv_n_out <= !on;
        addr_out <= a;
        hold(6);
    endtask
    // Burst clock stays low outside reads; the setup register picks which edge is active
    task automatic edge_rise;
        bclk_out <= 1'b1;
        hold(6);
    endtask
    task automatic edge_fall;
        bclk_out <= 1'b0;
        hold(4);
    endtask
    task automatic pin_reset;
        rst_n_out <= 1'b0;
        hold(6);
        rst_n_out <= 1'b1;
        hold(6);
    endtask
    initial begin
        {cs_n_out, oe_n_out, we_n_out, adv_n_out, rst_n_out} = 5'h1F;
        bclk_out = 1'b0;
        addr_out = 24'h000000;
        data_out = 16'h0000;
    end
endmodule // brc_host_model

// ==== testbench/brc_burst_read_config_wait_bench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module brc_burst_read_config_wait_bench;
    import brc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n, oe_n, we_n, adv_n, bclk, rst_n, wt, wt_oe_n, d_oe_n, req, rdy;
    logic [ADDR_W-1:0] a, arr_a;
    logic [DATA_W-1:0] din, dout, setup;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 clk = !clk;
    // Array answers at once with its own address as data
    brc_host_model brc_host_model_i (.clk_in(clk), .cs_n_out(cs_n), .oe_n_out(oe_n),
        .we_n_out(we_n), .adv_n_out(adv_n), .bclk_out(bclk), .rst_n_out(rst_n),
        .addr_out(a), .data_out(din));
    brc_burst_read_config_wait brc_burst_read_config_wait_i (.sys_clk_in(clk),
        .arst_n_in(arst_n), .chip_select_n_in(cs_n), .output_enable_n_in(oe_n),
        .write_enable_n_in(we_n), .address_valid_n_in(adv_n), .burst_clk_in(bclk),
        .reset_n_in(rst_n), .address_in(a), .data_pins_in(din), .data_pins_out(dout),
        .data_pins_oe_n_out(d_oe_n), .wait_out(wt), .wait_oe_n_out(wt_oe_n),
        .array_addr_out(arr_a), .array_req_out(req), .array_valid_in(req),
        .array_data_in(arr_a[15:0]), .array_ready_out(rdy),
        .read_setup_register_out(setup));
    task automatic test_done;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Bounded wait for the setup register to reach a value
    task automatic wait_reg(input logic [15:0] exp);
        for (int i = 0; i < 20 && setup !== exp; i++) @(posedge clk);
        `CHK(setup, exp)
    endtask
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        wait_reg(16'hF94F);
        brc_host_model_i.sel(1'b1, 24'h000000);
        `CHK({wt, wt_oe_n}, 2'b10)
        brc_host_model_i.sel(1'b0, 24'h000000);
        `CHK(wt_oe_n, 1'b1)
        brc_host_model_i.cmd(CMD_CFG_SETUP, 24'h000000);
        brc_host_model_i.cmd(CMD_CFG_CONFIRM, 24'h00FFFF);
        wait_reg(16'hFD4F);
        brc_host_model_i.cmd(CMD_CFG_SETUP, 24'h000000);
        brc_host_model_i.cmd(CMD_CFG_CONFIRM, 24'h001C49);
        wait_reg(16'h1C49);
        brc_host_model_i.cmd(CMD_IDENT, 24'h000005);
        brc_host_model_i.sel(1'b1, 24'h000005);
        // Latency 3, wait active high with the data, four-word burst
        for (int e = 0; e < 8; e++) begin
            brc_host_model_i.edge_rise();
            if (e < 3) `CHK(wt, 1'b1)
            else `CHK({wt, dout}, {1'b0, 16'h1C49})
            brc_host_model_i.edge_fall();
        end
        `CHK({wt_oe_n, d_oe_n}, 2'b00)
        brc_host_model_i.sel(1'b0, 24'h000000);
        // Array burst from word 2: the array returns its address, four words then held
        brc_host_model_i.cmd(CMD_READ_ARRAY, 24'h000000);
        brc_host_model_i.sel(1'b1, 24'h000002);
        for (int e = 0; e < 8; e++) begin
            brc_host_model_i.edge_rise();
            if (e < 3) `CHK(wt, 1'b1)
            else `CHK({wt, dout}, {1'b0, 16'(e < 7 ? e - 1 : 5)})
            brc_host_model_i.edge_fall();
        end
        // Prefetch stops with the FIFO full: eight ahead plus the four words taken
        `CHK({req, rdy, arr_a}, {2'b10, 24'h00000E})
        brc_host_model_i.sel(1'b0, 24'h000000);
        `CHK({req, rdy, wt_oe_n, d_oe_n}, 4'b0111)
        // Falling edge, latency 5, early active-low wait, continuous from row word 14
        brc_host_model_i.cmd(CMD_CFG_SETUP, 24'h000000);
        brc_host_model_i.cmd(CMD_CFG_CONFIRM, 24'h00290F);
        wait_reg(16'h290F);
        brc_host_model_i.sel(1'b1, 24'h00000E);
        for (int e = 0; e < 12; e++) begin
            brc_host_model_i.edge_rise();
            brc_host_model_i.edge_fall();
            `CHK(wt, (e == 4 || e == 5 || e > 9))
            if (e > 4) `CHK(dout, 16'(e < 6 ? 14 : (e < 11 ? 15 : 16)))
        end
        brc_host_model_i.sel(1'b0, 24'h000000);
        brc_host_model_i.pin_reset();
        wait_reg(16'hF94F);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule // brc_burst_read_config_wait_bench
